// *** pkg/zdw_pkg.sv ***
// Purpose: shared constants and types of the zone wiring diagnosis block
// Assumes: 20 MHz system clock, temperatures in whole degrees as signed words
// Notes:   byte offsets are those of the AXI4-Lite register map
package zdw_pkg;
  localparam int unsigned  N_ZONES      = 4;
  localparam int unsigned  ZW           = 2;        // zone index width
  localparam int unsigned  TW           = 12;       // temperature width, signed degrees
  localparam int unsigned  RW           = 7;        // drive ratio width, percent
  localparam int unsigned  WW           = 16;       // window register width
  localparam logic [31:0]  CODE_START   = 32'h0000_0258; // 600
  localparam logic [31:0]  CODE_ACK     = 32'h0000_025a; // 602
  localparam logic signed [TW:0] RISE_DEG = 13'sh005;    // 5 degrees
  localparam logic [RW-1:0] RATIO_FULL  = 7'h64;    // 100 percent
  localparam logic [RW-1:0] RATIO_ZERO  = 7'h00;
  localparam logic signed [TW-1:0] RES_OK        = 12'sh000; // 0
  localparam logic signed [TW-1:0] RES_NORESP    = 12'sh309; // 777
  localparam logic signed [TW-1:0] RES_ZERO_RISE = 12'sh378; // 888
  localparam logic signed [TW-1:0] RES_FAIL      = 12'sh3e7; // 999
  // time base: one tick every 100 ms, window counted in ticks
  localparam int unsigned  CLK_HZ       = 20_000_000;
  localparam int unsigned  TICK_MS      = 100;
  localparam int unsigned  TICK_CYCLES  = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned  ALT_MS       = 500;      // display alternation half period
  localparam logic [2:0]   ALT_TICKS    = 3'(ALT_MS / TICK_MS);
  localparam logic [WW-1:0] WINDOW_RST  = 16'h012c; // 300 ticks = 30 s
  localparam logic [N_ZONES-1:0] ZONE_ON_RST = 4'hf;
  // register byte offsets
  localparam logic [7:0]   OFF_CODE     = 8'h00;
  localparam logic [7:0]   OFF_WINDOW   = 8'h04;
  localparam logic [7:0]   OFF_ZONE_ON  = 8'h08;
  localparam logic [7:0]   OFF_STATUS   = 8'h0c;
  localparam logic [7:0]   OFF_RESULT0  = 8'h10;
  // status fields
  localparam int unsigned  ST_STATE_LSB = 0;
  localparam int unsigned  ST_ZONE_LSB  = 8;
  localparam int unsigned  ST_ABZ_LSB   = 12;
  localparam int unsigned  ST_PART_LSB  = 16;
  localparam logic [1:0]   RESP_OKAY    = 2'h0;
  localparam logic [1:0]   RESP_SLVERR  = 2'h2;

  typedef enum logic [2:0] {ST_IDLE, ST_PH1, ST_PH2_SETUP, ST_PH2, ST_DONE, ST_ABORT}
    zdw_state_t;
  // what a zone display shows
  typedef enum logic [2:0] {DSP_NORMAL, DSP_BLANK, DSP_GROUP_RUN, DSP_SINGLE_CHECK,
    DSP_RESULT_IND, DSP_ABORT_IND, DSP_NUMBER} zdw_disp_t;
endpackage

// *** rtl/zdw_diag.sv ***
// Purpose: sensor to heater wiring diagnosis sequencer with AXI4-Lite registers
// Assumes: temperatures, sensor faults and regulator ratios come from same-clock logic
// Notes:
// Function
// - test starts only when software writes the start code 600
// - inactive zones take no part in either phase nor in results
// - programmed window sets the time allowed for a temperature response
// - phase one forces active zones with positive setpoint to zero drive
// - phase one shows group message on participants, others blank
// - rise of five degrees in phase one aborts, display alternates fault
// - abort stays latched until the acknowledge code 602
// - phase one lasts exactly one window, then single checks begin; ticks run free, so it may end up to one tick early
// - phase two drives one zone at full ratio, watches five degree rise
// - zone under single check shows its single check message
// - after all checks displays alternate result indicator and result code
// - result zero when sensor answers its own heater
// - sensor answering another heater reports that channel number
// - reversed sensor reports the channel number negated
// - no rise within the window reports the no-response code
// - sensor failure reports 999, rise at zero drive reports 888
// - test always completes unless phase one sees a rise; here code 602 also ends it in either phase
// - acknowledge code after completion ends test and clears results
//
// Chosen here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
module zdw_diag #(
  parameter int unsigned TICK_CYCLES = zdw_pkg::TICK_CYCLES
) (
  input  wire logic                                        aclk,
  input  wire logic                                        aresetn,
  input  wire logic [7:0]                                  s_axi_awaddr,
  input  wire logic [2:0]                                  s_axi_awprot,
  input  wire logic                                        s_axi_awvalid,
  output logic                                             s_axi_awready,
  input  wire logic [31:0]                                 s_axi_wdata,
  input  wire logic [3:0]                                  s_axi_wstrb,
  input  wire logic                                        s_axi_wvalid,
  output logic                                             s_axi_wready,
  output logic [1:0]                                       s_axi_bresp,
  output logic                                             s_axi_bvalid,
  input  wire logic                                        s_axi_bready,
  input  wire logic [7:0]                                  s_axi_araddr,
  input  wire logic [2:0]                                  s_axi_arprot,
  input  wire logic                                        s_axi_arvalid,
  output logic                                             s_axi_arready,
  output logic [31:0]                                      s_axi_rdata,
  output logic [1:0]                                       s_axi_rresp,
  output logic                                             s_axi_rvalid,
  input  wire logic                                        s_axi_rready,
  input  wire logic [zdw_pkg::N_ZONES*zdw_pkg::TW-1:0]     zone_temp,
  input  wire logic [zdw_pkg::N_ZONES-1:0]                 sensor_fail,
  input  wire logic [zdw_pkg::N_ZONES-1:0]                 setpoint_pos,
  input  wire logic [zdw_pkg::N_ZONES*zdw_pkg::RW-1:0]     reg_ratio,
  output logic [zdw_pkg::N_ZONES*zdw_pkg::RW-1:0]          drive_ratio,
  output logic [zdw_pkg::N_ZONES*3-1:0]                    disp_kind,
  output logic [zdw_pkg::N_ZONES*zdw_pkg::TW-1:0]          disp_num,
  output logic                                             test_busy
);
  localparam int unsigned N  = zdw_pkg::N_ZONES;
  localparam int unsigned TW = zdw_pkg::TW;
  localparam logic [zdw_pkg::ZW-1:0] LAST_ZONE = zdw_pkg::ZW'(N - 1);

  zdw_pkg::zdw_state_t        state_q;
  logic [zdw_pkg::WW-1:0]     window_q;
  logic [N-1:0]               zone_on_q;
  logic [N-1:0]               part_q;
  logic [zdw_pkg::ZW-1:0]     zone_q;
  logic [zdw_pkg::ZW-1:0]     abort_zone_q;
  logic [zdw_pkg::WW-1:0]     win_cnt_q;
  logic [2:0]                 alt_cnt_q;
  logic                       alt_q;
  logic signed [TW-1:0]       base_q [N];
  logic signed [TW-1:0]       conn_q [N];
  logic signed [TW-1:0]       result_q [N];
  logic signed [TW-1:0]       code_w [N];
  logic signed [TW-1:0]       temp_w [N];
  logic [N-1:0]               hit_q;
  logic [N-1:0]               dbl_q;
  logic [N-1:0]               fail_q;
  logic [N-1:0]               rise_w;
  logic [N-1:0]               fall_w;
  logic [N-1:0]               ph1_rise_w;
  logic [zdw_pkg::ZW-1:0]     rise_zone_w;
  logic                       tick;
  logic                       win_done;
  logic [zdw_pkg::ZW-1:0]     next_part_w;
  logic                       next_found_w;
  logic [7:0]                 awaddr_q;
  logic                       aw_full_q;
  logic [31:0]                wdata_q;
  logic [3:0]                 wstrb_q;
  logic                       w_full_q;
  logic                       wr_en;
  logic                       code_start;
  logic                       code_ack;
  logic [31:0]                rdata_d;
  logic                       rd_hit_d;

  zdw_tick #(
    .CYCLES (TICK_CYCLES)
  ) u_tick (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (tick)
  );

  // per zone: unpack, compare against baseline, compute the final code
  for (genvar z = 0; z < N; z++)
  begin : g_zone
    assign temp_w[z] = zone_temp[z*TW +: TW];
    zdw_rise u_rise (
      .temp (temp_w[z]),
      .base (base_q[z]),
      .rise (rise_w[z]),
      .fall (fall_w[z])
    );
    assign ph1_rise_w[z] = zone_on_q[z] & rise_w[z] & ~sensor_fail[z];
    always_comb
    begin
      if (fail_q[z])
        code_w[z] = zdw_pkg::RES_FAIL;
      else if (dbl_q[z])
        code_w[z] = zdw_pkg::RES_ZERO_RISE;
      else if (!hit_q[z])
        code_w[z] = zdw_pkg::RES_NORESP;
      else if (conn_q[z] == TW'(z + 1))
        code_w[z] = zdw_pkg::RES_OK;
      else
        code_w[z] = conn_q[z];
    end
  end

  // lowest zone that rose in phase one, recorded for the fault display
  always_comb
  begin
    rise_zone_w = '0;
    for (int i = N - 1; i >= 0; i--)
      if (ph1_rise_w[i])
        rise_zone_w = zdw_pkg::ZW'(i);
  end

  // next participating zone above the current one, ascending order
  always_comb
  begin
    next_part_w  = '0;
    next_found_w = 1'b0;
    for (int i = N - 1; i >= 0; i--)
      if (part_q[i] && (zdw_pkg::ZW'(i) > zone_q))
      begin
        next_part_w  = zdw_pkg::ZW'(i);
        next_found_w = 1'b1;
      end
  end

  // AXI4-Lite write: address and data taken in either order, then one response
  assign s_axi_awready = !aw_full_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_full_q && !s_axi_bvalid;
  assign wr_en         = aw_full_q && w_full_q && !s_axi_bvalid;
  assign code_start    = wr_en && (awaddr_q == zdw_pkg::OFF_CODE)
                         && (wdata_q == zdw_pkg::CODE_START);
  assign code_ack      = wr_en && (awaddr_q == zdw_pkg::OFF_CODE)
                         && (wdata_q == zdw_pkg::CODE_ACK);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
    end
    else if (wr_en)
    begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_full_q <= 1'b1;
        awaddr_q  <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_full_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
    end
  end

  // write response, error on any address above the status register, result registers included
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= zdw_pkg::RESP_OKAY;
    end
    else if (wr_en)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (awaddr_q <= zdw_pkg::OFF_STATUS) ? zdw_pkg::RESP_OKAY
                                                         : zdw_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // configuration writes, honouring byte strobes
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      window_q  <= zdw_pkg::WINDOW_RST;
      zone_on_q <= zdw_pkg::ZONE_ON_RST;
    end
    else if (wr_en && (state_q == zdw_pkg::ST_IDLE))  // frozen while a test runs
    begin
      if (awaddr_q == zdw_pkg::OFF_WINDOW)
      begin
        if (wstrb_q[0]) window_q[7:0]  <= wdata_q[7:0];
        if (wstrb_q[1]) window_q[15:8] <= wdata_q[15:8];
      end
      if ((awaddr_q == zdw_pkg::OFF_ZONE_ON) && wstrb_q[0])
        zone_on_q <= wdata_q[N-1:0];
    end
  end

  // read data mux
  always_comb
  begin
    rdata_d  = '0;
    rd_hit_d = 1'b1;
    case (s_axi_araddr[7:2])
      zdw_pkg::OFF_CODE[7:2]:    rdata_d = '0;
      zdw_pkg::OFF_WINDOW[7:2]:  rdata_d[zdw_pkg::WW-1:0] = window_q;
      zdw_pkg::OFF_ZONE_ON[7:2]: rdata_d[N-1:0] = zone_on_q;
      zdw_pkg::OFF_STATUS[7:2]:
      begin
        rdata_d[zdw_pkg::ST_STATE_LSB +: 3]        = state_q;
        rdata_d[zdw_pkg::ST_ZONE_LSB +: zdw_pkg::ZW] = zone_q;
        rdata_d[zdw_pkg::ST_ABZ_LSB +: zdw_pkg::ZW]  = abort_zone_q;
        rdata_d[zdw_pkg::ST_PART_LSB +: N]           = part_q;
      end
      default:
      begin
        rd_hit_d = 1'b0;
        for (int i = 0; i < N; i++)
          if (s_axi_araddr[7:2] == 6'(zdw_pkg::OFF_RESULT0[7:2] + i))
          begin
            rdata_d  = {{(32 - TW){result_q[i][TW-1]}}, result_q[i]};
            rd_hit_d = 1'b1;
          end
      end
    endcase
  end

  // AXI4-Lite read: one beat, answered the cycle after the address is taken
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= zdw_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rdata_d;
      s_axi_rresp  <= rd_hit_d ? zdw_pkg::RESP_OKAY : zdw_pkg::RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // window timer, counts ticks from the start of each phase or zone check
  assign win_done = tick && ((win_cnt_q + 1'b1) >= window_q);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      win_cnt_q <= '0;
    else if ((state_q != zdw_pkg::ST_PH1) && (state_q != zdw_pkg::ST_PH2))
      win_cnt_q <= '0;
    else if (win_done)
      win_cnt_q <= '0;
    else if (tick)
      win_cnt_q <= win_cnt_q + 1'b1;
  end

  // sequencer
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q      <= zdw_pkg::ST_IDLE;
      part_q       <= '0;
      zone_q       <= '0;
      abort_zone_q <= '0;
    end
    else
    begin
      unique case (state_q)
        zdw_pkg::ST_IDLE:
          if (code_start)
          begin
            state_q <= zdw_pkg::ST_PH1;
            part_q  <= zone_on_q & setpoint_pos;
            zone_q  <= '0;
          end
        zdw_pkg::ST_PH1:
          if (code_ack)
            state_q <= zdw_pkg::ST_IDLE;
          else if (|ph1_rise_w)
          begin
            state_q      <= zdw_pkg::ST_ABORT;
            abort_zone_q <= rise_zone_w;
          end
          else if (win_done)
          begin
            state_q <= zdw_pkg::ST_PH2_SETUP;
            zone_q  <= '0;
            if (!part_q[0])
            begin
              zone_q <= next_part_w;
              if (!next_found_w)
                state_q <= zdw_pkg::ST_DONE;
            end
          end
        zdw_pkg::ST_PH2_SETUP:
          state_q <= code_ack ? zdw_pkg::ST_IDLE : zdw_pkg::ST_PH2;
        zdw_pkg::ST_PH2:
          if (code_ack)
            state_q <= zdw_pkg::ST_IDLE;
          else if (win_done)
          begin
            if (next_found_w && (zone_q != LAST_ZONE))
            begin
              zone_q  <= next_part_w;
              state_q <= zdw_pkg::ST_PH2_SETUP;
            end
            else
              state_q <= zdw_pkg::ST_DONE;
          end
        zdw_pkg::ST_DONE,
        zdw_pkg::ST_ABORT:
          if (code_ack)
          begin
            state_q <= zdw_pkg::ST_IDLE;
            part_q  <= '0;
            zone_q  <= '0;
          end
      endcase
    end
  end

  // baselines taken at phase one start and at each single check start
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      for (int i = 0; i < N; i++)
        base_q[i] <= '0;
    else if (code_start || (state_q == zdw_pkg::ST_PH2_SETUP))
      for (int i = 0; i < N; i++)
        base_q[i] <= temp_w[i];
  end

  // attribution of each sensor to the heater that moved it
  always_ff @(posedge aclk)
  begin
    if (!aresetn || code_start || code_ack)
    begin
      hit_q  <= '0;
      dbl_q  <= '0;
      fail_q <= '0;
      for (int i = 0; i < N; i++)
        conn_q[i] <= '0;
    end
    else if ((state_q == zdw_pkg::ST_PH1) || (state_q == zdw_pkg::ST_PH2))
    begin
      fail_q <= fail_q | (part_q & sensor_fail);
      if (state_q == zdw_pkg::ST_PH2)
        for (int i = 0; i < N; i++)
          if (part_q[i] && (rise_w[i] || fall_w[i]))
          begin
            if (hit_q[i] && (conn_q[i] != TW'(zone_q) + 1'b1)
                && (conn_q[i] != -(TW'(zone_q) + 1'b1)))
              dbl_q[i] <= 1'b1;
            else if (!hit_q[i])
            begin
              hit_q[i]  <= 1'b1;
              conn_q[i] <= rise_w[i] ? TW'(zone_q) + 1'b1
                                     : -(TW'(zone_q) + 1'b1);
            end
          end
    end
  end

  // final codes frozen at completion, cleared by the acknowledge
  always_ff @(posedge aclk)
  begin
    if (!aresetn || code_ack || code_start)
      for (int i = 0; i < N; i++)
        result_q[i] <= zdw_pkg::RES_OK;
    else if ((state_q == zdw_pkg::ST_PH2) && (state_q != zdw_pkg::ST_DONE) && win_done
             && !(next_found_w && (zone_q != LAST_ZONE)))
      for (int i = 0; i < N; i++)
        result_q[i] <= part_q[i] ? code_w[i] : zdw_pkg::RES_OK;
  end

  // display alternation every half second
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      alt_cnt_q <= '0;
      alt_q     <= 1'b0;
    end
    else if (tick)
    begin
      if (alt_cnt_q + 1'b1 >= zdw_pkg::ALT_TICKS)
      begin
        alt_cnt_q <= '0;
        alt_q     <= ~alt_q;
      end
      else
        alt_cnt_q <= alt_cnt_q + 1'b1;
    end
  end

  // registered drive ratios and zone displays
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      drive_ratio <= '0;
      disp_kind   <= '0;
      disp_num    <= '0;
      test_busy   <= 1'b0;
    end
    else
    begin
      test_busy <= (state_q != zdw_pkg::ST_IDLE);
      for (int i = 0; i < N; i++)
      begin
        drive_ratio[i*zdw_pkg::RW +: zdw_pkg::RW] <= reg_ratio[i*zdw_pkg::RW +: zdw_pkg::RW];
        disp_kind[i*3 +: 3] <= zdw_pkg::DSP_NORMAL;
        disp_num[i*TW +: TW] <= result_q[i];
        if (state_q != zdw_pkg::ST_IDLE)
        begin
          if (part_q[i])
            drive_ratio[i*zdw_pkg::RW +: zdw_pkg::RW] <= zdw_pkg::RATIO_ZERO;
          if (!part_q[i])
            disp_kind[i*3 +: 3] <= zdw_pkg::DSP_BLANK;
          else if (state_q == zdw_pkg::ST_PH1)
            disp_kind[i*3 +: 3] <= zdw_pkg::DSP_GROUP_RUN;
          else if (state_q == zdw_pkg::ST_DONE)
            disp_kind[i*3 +: 3] <= alt_q ? zdw_pkg::DSP_NUMBER
                                         : zdw_pkg::DSP_RESULT_IND;
          else if (state_q == zdw_pkg::ST_ABORT)
            disp_kind[i*3 +: 3] <= zdw_pkg::DSP_BLANK;
          else if (zone_q == zdw_pkg::ZW'(i))
          begin
            disp_kind[i*3 +: 3] <= zdw_pkg::DSP_SINGLE_CHECK;
            drive_ratio[i*zdw_pkg::RW +: zdw_pkg::RW] <= zdw_pkg::RATIO_FULL;
          end
          else
            disp_kind[i*3 +: 3] <= zdw_pkg::DSP_BLANK;
          if ((state_q == zdw_pkg::ST_ABORT) && (abort_zone_q == zdw_pkg::ZW'(i)))
            disp_kind[i*3 +: 3] <= alt_q ? zdw_pkg::DSP_ABORT_IND
                                         : zdw_pkg::DSP_RESULT_IND;
        end
      end
    end
  end
endmodule // zdw_diag

// *** rtl/zdw_rise.sv ***
// Purpose: compares one sensor against its captured baseline
// Assumes: temperatures are signed degrees on the same clock
// Notes:   purely combinational, one per zone
`timescale 1ns/10ps
module zdw_rise (
  input  wire logic signed [zdw_pkg::TW-1:0] temp,
  input  wire logic signed [zdw_pkg::TW-1:0] base,
  output logic                               rise,
  output logic                               fall
);
  logic signed [zdw_pkg::TW:0] diff;

  // one extra bit keeps the difference from wrapping
  assign diff = {temp[zdw_pkg::TW-1], temp} - {base[zdw_pkg::TW-1], base};
  assign rise = (diff >= zdw_pkg::RISE_DEG);
  assign fall = (diff <= -zdw_pkg::RISE_DEG);
endmodule // zdw_rise

// *** rtl/zdw_tick.sv ***
// Purpose: divider giving a one-cycle enable pulse every CYCLES clocks
// Assumes: CYCLES of at least two
// Notes:   counter restarts on reset only
`timescale 1ns/10ps
module zdw_tick #(
  parameter int unsigned CYCLES = zdw_pkg::TICK_CYCLES
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  output logic      tick
);
  localparam int unsigned CW = $clog2(CYCLES);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
  logic [CW-1:0] cnt_q;

  // free running count, pulse on the last value
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cnt_q <= '0;
    else if (cnt_q == LAST)
      cnt_q <= '0;
    else
      cnt_q <= cnt_q + 1'b1;
  end

  assign tick = (cnt_q == LAST);
endmodule // zdw_tick

// *** verification/test_zdw_diag.sv ***
// Purpose: self-checking bench of the wiring diagnosis sequencer
// Assumes: tick of 20 cycles, window of two ticks
// Notes:   bus answers are checked by a watcher against queues
`timescale 1ns/10ps
module test_zdw_diag;
  logic        aclk = 1'h0, aresetn = 1'h0, leak = 1'h0;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  setpoint_pos = 4'hf, sensor_fail = 4'h0; // setpoints above zero
  logic [27:0] reg_ratio = 28'h0, drive_ratio;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        test_busy;
  logic [1:0]  s_axi_bresp, s_axi_rresp, bq [$];
  logic [11:0] disp_kind;
  logic [47:0] zone_temp, disp_num;
  logic [33:0] rq [$];
  int          n_mismatch = 0, tests_run = 0, seed = 9, n;
  // 50 ns clock
  always #25 aclk = ~aclk;
  zdw_diag #(.TICK_CYCLES(20)) u_zdw_diag (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .zone_temp, .sensor_fail, .setpoint_pos, .reg_ratio,
    .drive_ratio, .disp_kind, .disp_num, .test_busy);
  zdw_plant u_zdw_plant (.aclk, .leak, .drive_ratio, .zone_temp);
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [33:0] e, input logic [33:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bound(input int k, input int lim);
    if (k >= lim)
    begin
      n_mismatch++;
      stop_test();
    end
  endtask
  task automatic fin(input int k);
    s_axi_bready <= 1'h0;
    s_axi_rready <= 1'h0;
    bound(k, 99);
    @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int k;
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (k = 0; k < 99 && !(s_axi_bvalid && k > 0); k++)
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end
    fin(k);
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    int k;
    rq.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (k = 0; k < 99 && !(s_axi_rvalid && k > 0); k++)
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end
    fin(k);
  endtask
  task automatic wait_kind(input logic [2:0] d, output int i);
    for (i = 0; i < 999 && disp_kind[2:0] !== d; i++)
      @(posedge aclk);
    bound(i, 999);
  endtask
  // watcher pairs each bus answer with the oldest note
  always @(posedge aclk)
  begin
    if (s_axi_bvalid && s_axi_bready) cmp("bresp", bq.pop_front(), s_axi_bresp);
    if (s_axi_rvalid && s_axi_rready) cmp("rdata", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
  end
  // main sequence: reset values, full run, abort run, sensor failure run
  initial
  begin
    for (int z = 0; z < 4; z++)
      reg_ratio[z*7+:7] <= 7'($unsigned($random(seed)) % 100);
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rd(8'h04, 34'h12c);
    rd(8'h08, 34'h00f);
    rd(8'h40, 34'h200000000);
    wr(8'h10, 32'h1, 2'h2);
    cmp("idle", reg_ratio, drive_ratio);
    wr(8'h04, 32'h2, 2'h0);
    wr(8'h08, 32'h7, 2'h0);
    wr(8'h00, 32'h259, 2'h0);
    cmp("no start", 34'h0, test_busy);
    wr(8'h00, 32'h258, 2'h0);
    @(negedge aclk);
    cmp("group", 34'(zdw_pkg::DSP_GROUP_RUN), disp_kind[2:0]);
    cmp("dark", 34'(zdw_pkg::DSP_BLANK), disp_kind[11:9]);
    cmp("zero", 34'h0, drive_ratio[20:0]);
    @(posedge aclk);
    wait_kind(zdw_pkg::DSP_SINGLE_CHECK, n);
    cmp("phase one", 34'h1, n inside {[17:42]});
    wait_kind(zdw_pkg::DSP_RESULT_IND, n);
    wait_kind(zdw_pkg::DSP_NUMBER, n);
    cmp("number", 34'h3, disp_num[23:12]);
    cmp("dark done", 34'(zdw_pkg::DSP_BLANK), disp_kind[11:9]);
    rd(8'h10, 34'h0);
    rd(8'h14, 34'h3);
    rd(8'h18, 34'h0fffffffe);
    rd(8'h1c, 34'h0);
    wr(8'h00, 32'h25a, 2'h0);
    rd(8'h14, 34'h0);
    cmp("ended", 34'h0, test_busy);
    leak <= 1'h1;
    wr(8'h00, 32'h258, 2'h0);
    wait_kind(zdw_pkg::DSP_ABORT_IND, n);
    leak <= 1'h0;
    repeat (99) @(posedge aclk);
    cmp("latched", 34'h1, test_busy);
    wr(8'h00, 32'h25a, 2'h0);
    cmp("cleared", 34'h0, test_busy);
    sensor_fail <= 4'h1;
    wr(8'h00, 32'h258, 2'h0);
    wait_kind(zdw_pkg::DSP_RESULT_IND, n);
    rd(8'h10, 34'h3e7);
    stop_test();
  end
endmodule // test_zdw_diag

// *** verification/zdw_diag_assertions.sv ***
// Purpose: port checks of the wiring diagnosis sequencer
// Assumes: one clock, synchronous active-low reset
// Notes:   bound into every zdw_diag
`timescale 1ns/10ps
module zdw_diag_chk (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [27:0] reg_ratio,
  input wire logic [27:0] drive_ratio,
  input wire logic [11:0] disp_kind,
  input wire logic        test_busy
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic [3:0] full;
  // zones held at full ratio
  always_comb
  begin
    for (int z = 0; z < 4; z++)
      full[z] = drive_ratio[z*7+:7] == zdw_pkg::RATIO_FULL;
  end
  chk_idle_pass: assert property ($past(aresetn) && $past(!test_busy) && !test_busy
    && $stable(reg_ratio) |-> drive_ratio == reg_ratio) else $error("idle drive");
  chk_idle_disp: assert property ($past(aresetn) && $past(!test_busy) && !test_busy
    |-> disp_kind == 12'h000) else $error("idle display");
  chk_one_full: assert property (test_busy |-> $onehot0(full))
    else $error("two zones at full");
  chk_group_off: assert property ((disp_kind[2:0] == zdw_pkg::DSP_GROUP_RUN) [*2]
    |-> drive_ratio[6:0] == zdw_pkg::RATIO_ZERO) else $error("group drive");
  chk_group_dark: assert property (disp_kind[2:0] == zdw_pkg::DSP_GROUP_RUN
    |-> disp_kind[11:9] inside {zdw_pkg::DSP_BLANK, zdw_pkg::DSP_GROUP_RUN})
    else $error("group display");
  chk_single_on: assert property ((disp_kind[2:0] == zdw_pkg::DSP_SINGLE_CHECK) [*3]
    |-> full[0]) else $error("single drive");
  chk_start_code: assert property ($rose(test_busy)
    |-> $past(s_axi_wdata) == zdw_pkg::CODE_START) else $error("start code");
  chk_abort_busy: assert property (disp_kind[2:0] == zdw_pkg::DSP_ABORT_IND
    |-> test_busy) else $error("abort");
  chk_done_off: assert property (disp_kind[2:0] == zdw_pkg::DSP_NUMBER
    |-> test_busy && !full[0]) else $error("done");
endmodule // zdw_diag_chk
bind zdw_diag zdw_diag_chk u_zdw_diag_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_wdata(s_axi_wdata), .reg_ratio(reg_ratio), .drive_ratio(drive_ratio),
  .disp_kind(disp_kind), .test_busy(test_busy));

// *** verification/zdw_plant.sv ***
// Purpose: heated zones with miswired sensors
// Assumes: one degree per cycle while a heater drives
// Notes:   leak heats zone 0 at zero drive
`timescale 1ns/10ps
module zdw_plant (
  input  wire logic        aclk,
  input  wire logic        leak,
  input  wire logic [27:0] drive_ratio,
  output logic      [47:0] zone_temp
);
  // sensor z hears heater src[z]; zone 2 reversed
  localparam int SRC [4] = '{0, 2, 1, 3};
  initial zone_temp = {4{12'h014}}; // cold start
  // integrate heat seen by each sensor
  always @(posedge aclk)
  begin
    for (int z = 0; z < 4; z++)
      if (drive_ratio[SRC[z]*7+:7] != 7'h00 || (leak && z == 0))
        zone_temp[z*12+:12] <= zone_temp[z*12+:12] + (z == 2 ? 12'hfff : 12'h001);
  end
endmodule // zdw_plant
